// *** hw/adc_seq0_input_select.sv ***
// Sequencer 0 per-slot analog input selection with Wishbone register access
`timescale 1ns/100ps

module adc_seq0_input_select
  import adc_seq0_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Sequencer core
  input  wire logic        seq_trigger,
  input  wire logic        conv_done,
  output logic             conv_start,
  output logic      [2:0]  slot_index,
  output logic             slot_last,
  output logic             seq_busy,
  output logic             seq_done,
  // Analog multiplexer
  output logic      [2:0]  mux_pos_input,
  output logic      [2:0]  mux_neg_input,
  output logic             mux_diff,
  output logic             mux_temp
);

  logic [31:0] select_reg;
  logic [31:0] select_next;
  logic [31:0] control_reg;
  logic [31:0] control_next;
  logic [31:0] write_mask;
  logic        access;
  logic        write_en;
  logic        start_cmd;
  logic [1:0]  cur_field;
  logic [3:0]  cur_flags;
  logic        cur_end;
  seq_state_e  state_reg;
  logic [2:0]  slot_reg;

  function automatic logic [31:0] byte_mask(input logic [3:0] sel);
    byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic [1:0] slot_field(input logic [31:0] sel_word,
                                            input logic [2:0]  slot);
    case (slot)
      3'h0:    slot_field = sel_word[1:0];
      3'h1:    slot_field = sel_word[5:4];
      3'h2:    slot_field = sel_word[9:8];
      3'h3:    slot_field = sel_word[13:12];
      3'h4:    slot_field = sel_word[17:16];
      3'h5:    slot_field = sel_word[21:20];
      3'h6:    slot_field = sel_word[25:24];
      3'h7:    slot_field = sel_word[29:28];
      default: slot_field = 2'h0;
    endcase
  endfunction

  assign access     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign write_en   = access && wb_we_i;
  assign write_mask = byte_mask(wb_sel_i);
  // Only field bits ever load, so the gaps can never hold anything but zero
  assign select_next  = (select_reg & ~(write_mask & SELECT_RW_MASK))
                      | (wb_dat_i & write_mask & SELECT_RW_MASK);
  assign control_next = (control_reg & ~(write_mask & CONTROL_RW_MASK))
                      | (wb_dat_i & write_mask & CONTROL_RW_MASK);
  assign start_cmd  = (write_en && wb_adr_i[7:2] == COMMAND_OFFSET[7:2]
                       && wb_sel_i[0] && wb_dat_i[START_POS]) || seq_trigger;

  // Fields are read live; a mid-sequence rewrite reaches the current slot's end test, other fields later slots only
  assign cur_field = slot_field(select_reg, slot_reg);
  assign cur_flags = control_reg[{slot_reg, 2'b00} +: FIELD_STRIDE];
  assign cur_end   = cur_flags[END_POS] || slot_reg == LAST_SLOT;

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= access;
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      select_reg <= SELECT_RESET;
    else if (write_en && wb_adr_i[7:2] == SELECT_OFFSET[7:2])
      select_reg <= select_next;
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      control_reg <= CONTROL_RESET;
    else if (write_en && wb_adr_i[7:2] == CONTROL_OFFSET[7:2])
      control_reg <= control_next;
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      wb_dat_o <= 32'h0000_0000;
    else if (access && !wb_we_i)
    begin
      case (wb_adr_i[7:2])
        SELECT_OFFSET[7:2]:  wb_dat_o <= select_reg & SELECT_RW_MASK;
        CONTROL_OFFSET[7:2]: wb_dat_o <= control_reg & CONTROL_RW_MASK;
        COMMAND_OFFSET[7:2]: wb_dat_o <= {25'h0, slot_reg, 3'h0, seq_busy};
        default:             wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      state_reg <= ST_IDLE;
      slot_reg  <= 3'h0;
      seq_busy  <= 1'b0;
      seq_done  <= 1'b0;
    end
    else
    begin
      seq_done <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (start_cmd)
          begin
            slot_reg  <= 3'h0;
            seq_busy  <= 1'b1;
            state_reg <= ST_PRESENT;
          end
        end
        ST_PRESENT: state_reg <= ST_SETTLE;
        ST_SETTLE:  state_reg <= ST_CONVERT;
        ST_CONVERT:
        begin
          if (conv_done)
          begin
            if (cur_end)
            begin
              seq_busy  <= 1'b0;
              seq_done  <= 1'b1;
              state_reg <= ST_IDLE;
            end
            else
            begin
              slot_reg  <= slot_reg + 3'h1;
              state_reg <= ST_PRESENT;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Mux settles a full cycle before the conversion strobe
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      mux_pos_input <= 3'h0;
      mux_neg_input <= 3'h0;
      mux_diff      <= 1'b0;
      mux_temp      <= 1'b0;
      slot_last     <= 1'b0;
    end
    else if (state_reg == ST_PRESENT)
    begin
      slot_last <= cur_end;
      if (cur_flags[TEMP_POS])
      begin
        // The sensor has no differential option
        mux_temp      <= 1'b1;
        mux_diff      <= 1'b0;
        mux_pos_input <= 3'h0;
        mux_neg_input <= 3'h0;
      end
      else if (cur_flags[DIFF_POS])
      begin
        mux_temp      <= 1'b0;
        mux_diff      <= 1'b1;
        mux_pos_input <= {cur_field, 1'b0};
        mux_neg_input <= {cur_field, 1'b1};
      end
      else
      begin
        mux_temp      <= 1'b0;
        mux_diff      <= 1'b0;
        mux_pos_input <= {1'b0, cur_field};
        mux_neg_input <= 3'h0;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      conv_start <= 1'b0;
    else
      conv_start <= state_reg == ST_SETTLE;
  end

  assign slot_index = slot_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_present_settle;
    state_reg == ST_PRESENT ##1 state_reg == ST_SETTLE;
  endsequence

  sequence s_last_done;
    state_reg == ST_CONVERT && conv_done && cur_end;
  endsequence

  sequence s_start_taken;
    state_reg == ST_IDLE && start_cmd;
  endsequence

  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_ack_follows_req: assert property (access |=> wb_ack_o)
    else $error("request not answered in one cycle");

  a_select_resets: assert property ($rose(reset_n) |-> select_reg == SELECT_RESET)
    else $error("selection fields not zero after reset");

  a_select_write: assert property (write_en && wb_adr_i == SELECT_OFFSET && wb_sel_i == 4'hF
      |=> select_reg == ($past(wb_dat_i) & SELECT_RW_MASK))
    else $error("selection write not stored");

  a_gap_reads_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == SELECT_OFFSET
      |-> (wb_dat_o & ~SELECT_RW_MASK) == 32'h0000_0000)
    else $error("gap bits read non-zero");

  a_present_start: assert property (s_present_settle |=> conv_start)
    else $error("conversion not started after settle");

  a_mux_stable: assert property (conv_start |-> $stable(mux_pos_input) && $stable(mux_temp)
      && $stable(mux_diff))
    else $error("mux changed with conversion strobe");

  a_single_field: assert property (conv_start && !mux_diff && !mux_temp
      |-> mux_pos_input == {1'b0, $past(cur_field, 2)})
    else $error("single input differs from field");

  a_diff_pair: assert property (conv_start && mux_diff
      |-> mux_pos_input[0] == 1'b0 && mux_neg_input == mux_pos_input + 3'h1)
    else $error("differential pair malformed");

  a_temp_no_diff: assert property (mux_temp |-> !mux_diff)
    else $error("temperature slot marked differential");

  a_end_stops: assert property (s_last_done |=> state_reg == ST_IDLE && seq_done
      ##1 !conv_start [*2])
    else $error("conversion continued past end slot");

  a_slot_steps: assert property (state_reg == ST_CONVERT && conv_done && !cur_end
      |=> slot_index == $past(slot_index) + 3'h1 ##2 conv_start)
    else $error("slot did not step upward");

  a_first_slot: assert property (s_start_taken |=> slot_index == 3'h0 && seq_busy)
    else $error("sequence did not begin at slot zero");

  a_done_not_busy: assert property (seq_done |-> !seq_busy)
    else $error("busy still set at sequence end");

  a_temp_zero_pins: assert property (mux_temp |-> mux_pos_input == 3'h0 && mux_neg_input == 3'h0)
    else $error("temperature slot drives a pin number");

  a_single_no_neg: assert property (!mux_diff |-> mux_neg_input == 3'h0)
    else $error("negative input set on single-ended slot");

endmodule

// *** hw/adc_seq0_pkg.sv ***
// Constants and types for the sequencer 0 analog input selection block
package adc_seq0_pkg;

  // Register byte offsets
  localparam logic [7:0] SELECT_OFFSET  = 8'h40;
  localparam logic [7:0] CONTROL_OFFSET = 8'h44;
  localparam logic [7:0] COMMAND_OFFSET = 8'h48;

  // Values after reset
  localparam logic [31:0] SELECT_RESET  = 32'h0000_0000;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

  // Writable bits; everything else reads as zero
  localparam logic [31:0] SELECT_RW_MASK  = 32'h3333_3333;
  localparam logic [31:0] CONTROL_RW_MASK = 32'hBBBB_BBBB;

  // Per-slot field layout
  localparam int          SLOT_COUNT   = 8;
  localparam int          FIELD_STRIDE = 4;
  localparam int          DIFF_POS     = 0;
  localparam int          END_POS      = 1;
  localparam int          TEMP_POS     = 3;
  localparam logic [2:0]  LAST_SLOT    = 3'h7;

  // Command and status layout
  localparam int          START_POS    = 0;
  localparam int          BUSY_POS     = 0;
  localparam int          SLOT_POS     = 4;

  typedef enum {ST_IDLE, ST_PRESENT, ST_SETTLE, ST_CONVERT} seq_state_e;

endpackage

// *** tb/adc_conv_model.sv ***
// Behavioural converter that answers each conversion request
`timescale 1ns/100ps
module adc_conv_model
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  // Sequencer side
  input  wire logic       conv_start,
  input  wire logic [2:0] mux_pos_input,
  input  wire logic [2:0] mux_neg_input,
  input  wire logic       mux_diff,
  input  wire logic       mux_temp,
  output logic            conv_done,
  // Record of what the last eight conversions sampled
  output int              count,
  output logic [7:0]      seen [8]
);
  int   wait_cnt;
  logic run;

  // Odd conversions answer slowly, even ones promptly
  always @(posedge clock)
  begin
    conv_done <= 1'b0;
    if (!reset_n)
    begin
      count <= 0;
      run   <= 1'b0;
    end
    else if (conv_start)
    begin
      seen[count[2:0]] <= {mux_temp, mux_diff, mux_neg_input, mux_pos_input};
      count            <= count + 1;
      wait_cnt         <= count[0] ? 5 : 0;
      run              <= 1'b1;
    end
    else if (run)
    begin
      if (wait_cnt == 0)
      begin
        conv_done <= 1'b1;
        run       <= 1'b0;
      end
      else
        wait_cnt <= wait_cnt - 1;
    end
  end
endmodule

// *** tb/tb_adc_seq0_input_select.sv ***
// Register and sequence tests for the input selection block
`timescale 1ns/100ps
module tb_adc_seq0_input_select
  import adc_seq0_pkg::*;
;
  logic clock = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, trig = 0, done, start;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, last, busy, sdone, diff, temp;
  logic [2:0] idx, pos, neg;
  logic [7:0] seen [8];
  int count, base, err_total, comparisons, busy_cycles;

  always #4 clock = ~clock;

  adc_seq0_input_select adc_seq0_input_select_inst (.clock(clock), .reset_n(reset_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .seq_trigger(trig),
    .conv_done(done), .conv_start(start), .slot_index(idx), .slot_last(last),
    .seq_busy(busy), .seq_done(sdone), .mux_pos_input(pos), .mux_neg_input(neg),
    .mux_diff(diff), .mux_temp(temp));

  adc_conv_model adc_conv_model_inst (.clock(clock), .reset_n(reset_n), .conv_start(start),
    .mux_pos_input(pos), .mux_neg_input(neg), .mux_diff(diff), .mux_temp(temp),
    .conv_done(done), .count(count), .seen(seen));

  task check(input string name, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Held until ack is sampled high, then released for a cycle
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clock);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clock); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task run_seq(input logic by_cmd);
    base        = count;
    busy_cycles = 0;
    if (by_cmd)
      wb(COMMAND_OFFSET, 1'b1, 32'h1);
    else
    begin
      @(posedge clock);
      trig <= 1'b1;
      @(posedge clock);
      trig <= 1'b0;
    end
    for (int i = 0; i < 300 && sdone !== 1'b1; i++)
    begin
      @(posedge clock);
      if (busy === 1'b1)
        busy_cycles++;
    end
  endtask

  task print_verdict;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    wb(SELECT_OFFSET, 1'b0, 0);
    check("select reset", q, 32'h0000_0000);
    wb(8'h80, 1'b0, 0);
    check("unmapped read", q, 32'h0000_0000);
    wb(SELECT_OFFSET, 1'b1, 32'hFFFF_FFFF);
    wb(SELECT_OFFSET, 1'b0, 0);
    check("gaps read zero", q, 32'h3333_3333);
    $display("test registers done");
    wb(SELECT_OFFSET, 1'b1, 32'h3210_3210);
    run_seq(1'b0);
    check("done pulse", sdone, 1'b1);
    check("busy seen", busy_cycles > 0, 1'b1);
    check("busy cleared", busy, 1'b0);
    check("last slot index", idx, 3'h7);
    check("last slot flag", last, 1'b1);
    check("slot count", count - base, 8);
    for (int i = 0; i < 8; i++)
      check("slot input", {24'h0, seen[i]}, i % 4);
    wb(COMMAND_OFFSET, 1'b0, 0);
    check("status read", q, 32'h0000_0070);
    $display("test eight slots done");
    wb(SELECT_OFFSET, 1'b0, 0);
    wb(SELECT_OFFSET, 1'b1, (q & ~SELECT_RW_MASK) | 32'h0000_0321);
    wb(CONTROL_OFFSET, 1'b1, 32'h0000_0281);
    wb(CONTROL_OFFSET, 1'b0, 0);
    check("flags read", q, 32'h0000_0281);
    run_seq(1'b1);
    check("end done pulse", sdone, 1'b1);
    check("end slot index", idx, 3'h2);
    check("end slot flag", last, 1'b1);
    check("end slot count", count - base, 3);
    wb(COMMAND_OFFSET, 1'b0, 0);
    check("end status read", q, 32'h0000_0020);
    check("diff slot", {24'h0, seen[base % 8]}, 8'h5A);
    check("temp slot", {24'h0, seen[(base + 1) % 8]}, 8'h80);
    check("plain slot", {24'h0, seen[(base + 2) % 8]}, 8'h03);
    $display("test flags done");
    print_verdict;
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    err_total++;
    print_verdict;
  end
endmodule
